// File: cfgp_port.sv
`timescale 1ns/100ps
`default_nettype none
module cfgp_port
  import cfgp_pkg::*;
#(
  parameter int MEM_BITS = 64,              // Own configuration memory size
  parameter int RB_BITS  = 64               // Readback image size in bits
) (
  input  wire logic                   clk,                 // System clock
  input  wire logic                   sys_rst,             // Synchronous reset, active high
  input  wire logic                   config_clock,        // Link clock from the host
  input  wire logic [1:0]             mode_sel,            // Slave serial or slave parallel
  input  wire logic                   din,                 // Serial configuration input
  input  wire logic [CFGP_BYTE_W-1:0] data_bus,            // Parallel configuration bytes
  input  wire logic                   strobe_n,            // Parallel write strobe
  input  wire logic                   chip_select_low,     // Active-low chip select
  input  wire logic                   chip_select_high,    // Active-high chip select
  input  wire logic                   readback_req_n,      // Readback request, active low
  input  wire logic [1:0]             rb_permission,       // Readback permission setting
  input  wire logic                   req_drives_readback, // After config: 1 readback, 0 tristate
  input  wire logic [1:0]             capture_mode,        // Logic-tile capture option
  input  wire logic                   capture_trig_n,      // Internal capture signal, active low
  input  wire logic [CFGP_TILE_OUTS-1:0] logic_tile,       // Logic-tile outputs
  output logic                        dout,                // Serial chain output
  output logic                        readback_data,       // Readback serial output
  output logic                        global_tristate,     // Global three-state, active high
  output logic                        config_done,         // Own configuration loaded (clk)
  output logic                        readback_busy,       // Readback running (clk)
  output logic                        select_error,        // Deselect during parallel load
  output logic [CFGP_TILE_OUTS-1:0]   capture_mem          // Captured logic-tile state
);

  // Clocking overview
  // The load path, the chain output and readback all run on config_clock.
  // Only the three status levels and the select error cross into the clk domain.
  // sys_rst is sampled by both domains, so the link clock must keep
  // running while reset is held, or the link flops keep stale state.
  // No word crosses domains; only single-bit levels, which are safe
  // through two flops because each bit settles long before it is read.

  // Mode handling
  // Slave serial: header, own frames, then forwarding down the chain.
  // Slave parallel: no header, one byte per edge, chain output idles high.
  // A parallel device can never lead a chain, so nothing is forwarded.

  // Link-domain state
  cfgp_state_t                st;                  // Load sequence state
  logic [CFGP_HEADER_W-1:0]   header;              // Preamble and length shift register
  logic [5:0]                 header_cnt;          // Header bits seen
  logic [CFGP_LENGTH_W-1:0]   length_count;        // Total bits from the stream
  logic [CFGP_LENGTH_W-1:0]   bit_count;           // Bits received after header
  logic [MEM_BITS-1:0]        cfg_mem;             // Own configuration memory
  logic [$clog2(MEM_BITS+1)-1:0] mem_fill;         // Bits stored so far
  logic                       dout_rise;           // Output value prepared on rising edge
  logic                       selected;            // Parallel device selected
  logic                       link_done;           // Configuration complete (link)
  logic                       sel_err;             // Deselected too early (link)
  wire                        par_mode = (mode_sel == CFGP_MODE_SLAVE_PARALLEL);
  wire                        sel_now  = !strobe_n && !chip_select_low && chip_select_high;

  // Number of storage bits taken per link edge
  // Shared by both load branches so the fill arithmetic stays in one place.
  function automatic logic [3:0] cfgp_step(input logic par);
    cfgp_step = par ? 4'h8 : 4'h1;
  endfunction : cfgp_step

  // Header and load sequence, sampled on rising link edge
  // Header bits are echoed so downstream devices see the same preamble.
  // Own frames are swallowed with a steady high on the chain output.
  // Bits past a full memory are forwarded, and forwarding goes on after the length is used up.
  // Deselection during a parallel load is sticky and stalls completion.
  always_ff @(posedge config_clock) begin
    if (sys_rst) begin
      st           <= CFGP_ST_HEADER;
      header       <= '0;
      header_cnt   <= '0;
      length_count <= '0;
      bit_count    <= '0;
      mem_fill     <= '0;
      selected     <= 1'b0;
      link_done    <= 1'b0;
      sel_err      <= 1'b0;
      dout_rise    <= 1'b1;
    end else begin
      case (st)
        CFGP_ST_HEADER: begin
          // Parallel devices skip the serial header and load straight away
          if (par_mode) begin
            if (sel_now) begin
              selected <= 1'b1;
              st       <= CFGP_ST_LOAD;
            end
          end else begin
            header     <= {header[CFGP_HEADER_W-2:0], din};
            header_cnt <= header_cnt + 6'h01;
            dout_rise  <= din; // Header retransmitted to the chain
            if (header_cnt == 6'(CFGP_HEADER_W-1)) begin
              length_count <= {header[CFGP_LENGTH_W-2:0], din};
              st           <= CFGP_ST_LOAD;
            end
          end
        end
        CFGP_ST_LOAD: begin
          // Own frames: keep output high so nobody downstream sees a start bit
          dout_rise <= 1'b1;
          if (par_mode) begin
            if (!sel_now) begin
              // Early deselect: flag it; no byte is taken until selected again
              sel_err <= 1'b1;
            end else begin
              mem_fill <= mem_fill + ($bits(mem_fill))'(cfgp_step(1'b1));
              // Done only on a byte actually taken while selected
              if (32'(mem_fill) + 32'(CFGP_BYTE_W) >= MEM_BITS) begin
                st        <= CFGP_ST_DONE;
                link_done <= 1'b1;
              end
            end
          end else begin
            bit_count <= bit_count + 24'h000001;
            mem_fill  <= mem_fill + ($bits(mem_fill))'(cfgp_step(1'b0));
            if (32'(mem_fill) + 32'h1 >= MEM_BITS) begin
              st        <= CFGP_ST_PASS;
              link_done <= 1'b1;
            end
          end
        end
        CFGP_ST_PASS: begin
          // Memory full: surplus bits go down the chain while below length
          if (bit_count < length_count) begin
            bit_count <= bit_count + 24'h000001;
            dout_rise <= din;
          end else begin
            // Length used up: keep retransmitting, no gap in the echo
            dout_rise <= din;
            st        <= CFGP_ST_DONE;
          end
        end
        CFGP_ST_DONE: begin
          dout_rise <= par_mode ? 1'b1 : din;
          if (par_mode && selected && !sel_now)
            selected <= 1'b0;
        end
        default: st <= CFGP_ST_HEADER;
      endcase
    end
  end

  // Configuration memory fill
  // Bytes and bits both enter at the low end, so the first byte or bit
  // ends up at the top of the memory, matching the MSB-first stream.
  // The memory is not cleared on completion; readback reads it as is.
  always_ff @(posedge config_clock) begin
    if (sys_rst) begin
      cfg_mem <= '0;
    end else if (st == CFGP_ST_LOAD) begin
      if (par_mode && sel_now)
        cfg_mem <= {cfg_mem[MEM_BITS-CFGP_BYTE_W-1:0], data_bus};
      else if (!par_mode)
        cfg_mem <= {cfg_mem[MEM_BITS-2:0], din};
    end
  end

  // Serial output changes on the falling link edge only
  // Half a cycle of setup for the next device, which samples on rising.
  // Readback never reaches this path; it has its own output.
  always_ff @(negedge config_clock) begin
    if (sys_rst)
      dout <= 1'b1;
    else
      dout <= dout_rise;
  end

  // Readback logic, link domain
  cfgp_rb_state_t             rb_st;               // Readback state
  logic                       req_q;               // Request sampled last edge
  logic [1:0]                 high_edges;          // Rising edges with request high
  logic [1:0]                 lat_cnt;             // Start latency counter
  logic [$clog2(RB_BITS)-1:0] rb_idx;              // Image bit index
  logic [4:0]                 frame_pos;           // Position inside a frame
  logic                       rb_spent;            // One-shot readback used
  logic                       entry_cap;           // Capture pulse on entry
  wire                        rb_enable = link_done && req_drives_readback;
  wire                        rb_allowed = (rb_permission == CFGP_RB_UNLIMITED) ||
                                           ((rb_permission == CFGP_RB_ONCE) && !rb_spent);
  wire [RB_BITS-1:0]          rb_image = cfg_mem[RB_BITS-1:0];

  // Readback sequencing; runs while the user design keeps working
  // A falling request edge starts; the request must then stay low.
  // Raising it aborts into a hold state, which counts high edges.
  // After two or more high edges the next falling edge restarts at frame 0.
  // Each frame: one low start bit, data bits, one high stop bit.
  // The image index wraps, so a long request repeats the image.
  // Limitation: captured tile state is not merged into the image.
  always_ff @(posedge config_clock) begin
    if (sys_rst) begin
      rb_st         <= CFGP_RB_IDLE;
      req_q         <= 1'b1;
      high_edges    <= '0;
      lat_cnt       <= '0;
      rb_idx        <= '0;
      frame_pos     <= '0;
      rb_spent      <= 1'b0;
      entry_cap     <= 1'b0;
      readback_data <= 1'b1;
    end else begin
      req_q     <= readback_req_n;
      entry_cap <= 1'b0;
      if (readback_req_n && high_edges != 2'h3)
        high_edges <= high_edges + 2'h1;
      else if (!readback_req_n)
        high_edges <= '0;
      case (rb_st)
        CFGP_RB_IDLE: begin
          readback_data <= 1'b1;
          // Falling request edge starts; one-shot permission refuses later ones
          if (rb_enable && req_q && !readback_req_n && rb_allowed) begin
            rb_st     <= CFGP_RB_WAIT;
            lat_cnt   <= '0;
            rb_idx    <= '0;
            frame_pos <= '0;
            entry_cap <= 1'b1;
            if (rb_permission == CFGP_RB_ONCE)
              rb_spent <= 1'b1;
          end
        end
        CFGP_RB_WAIT: begin
          if (readback_req_n) begin
            rb_st <= CFGP_RB_HOLD;
          end else if (lat_cnt == 2'(CFGP_RB_LATENCY-1)) begin
            rb_st         <= CFGP_RB_SHIFT;
            readback_data <= 1'b0;
            frame_pos     <= 5'h01;
          end else begin
            lat_cnt <= lat_cnt + 2'h1;
          end
        end
        CFGP_RB_SHIFT: begin
          if (readback_req_n) begin
            rb_st <= CFGP_RB_HOLD;
          end else if (frame_pos == 5'(CFGP_FRAME_DATA_W+1)) begin
            readback_data <= 1'b1; // Stop bit
            frame_pos     <= '0;
          end else if (frame_pos == 5'h00) begin
            readback_data <= 1'b0; // Next frame start
            frame_pos     <= 5'h01;
          end else begin
            readback_data <= rb_image[rb_idx]; // Data only, no header
            rb_idx        <= (32'(rb_idx) == RB_BITS-1) ? '0 : rb_idx + 1'b1;
            frame_pos     <= frame_pos + 5'h01;
          end
        end
        CFGP_RB_HOLD: begin
          readback_data <= 1'b1;
          // Restart from frame 0 after enough high edges
          if (!readback_req_n && high_edges >= 2'(CFGP_RESTART_EDGES) && rb_enable) begin
            rb_st   <= CFGP_RB_IDLE;
          end else if (high_edges >= 2'(CFGP_RESTART_EDGES)) begin
            rb_st <= CFGP_RB_IDLE;
          end
        end
        default: rb_st <= CFGP_RB_IDLE;
      endcase
    end
  end

  // Logic-tile capture into capture memory
  // The internal trigger is a level; held low it captures every edge.
  // Entry capture uses the one-cycle pulse from the readback start.
  always_ff @(posedge config_clock) begin
    if (sys_rst) begin
      capture_mem <= '0;
    end else begin
      case (capture_mode)
        CFGP_CAP_NONE:   capture_mem <= capture_mem;
        CFGP_CAP_ENTRY:  if (entry_cap) capture_mem <= logic_tile;
        CFGP_CAP_SIGNAL: if (!capture_trig_n) capture_mem <= logic_tile;
        CFGP_CAP_EITHER: if (entry_cap || !capture_trig_n) capture_mem <= logic_tile;
        default:         capture_mem <= capture_mem;
      endcase
    end
  end

  // Request pin serves tristate until configured, then per option
  // Registered so the tristate output never glitches on the pin edge.
  // Costs one link cycle of latency, acceptable for a test function.
  always_ff @(posedge config_clock) begin
    if (sys_rst)
      global_tristate <= 1'b0;
    else
      global_tristate <= (!link_done || !req_drives_readback) ? !readback_req_n : 1'b0;
  end

  // Status into the system domain through two-flop synchronisers
  // Each status bit is an independent level; no bit depends on another
  // being seen at the same clk edge, so no handshake is needed.
  cfgp_status_t link_status;                       // Level status bundle
  cfgp_status_t sync_a;                            // First stage, read only by second
  cfgp_status_t sync_b;                            // Second stage
  logic [1:0]   err_sync;                          // Select error synchroniser
  assign link_status = '{config_done: link_done,
                         readback_busy: (rb_st != CFGP_RB_IDLE),
                         readback_spent: rb_spent};

  // Level crossing, clk domain
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_a   <= '0;
      sync_b   <= '0;
      err_sync <= '0;
    end else begin
      sync_a   <= link_status;
      sync_b   <= sync_a;
      err_sync <= {err_sync[0], sel_err};
    end
  end

  // Registered status outputs
  // One more flop after the synchroniser, so outputs come from flops.
  // Spent flag is carried across but only used by the link logic.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      config_done   <= 1'b0;
      readback_busy <= 1'b0;
      select_error  <= 1'b0;
    end else begin
      config_done   <= sync_b.config_done;
      readback_busy <= sync_b.readback_busy;
      select_error  <= err_sync[1];
    end
  end


  // Notes for integrators
  // Image size and memory size are parameters; keep RB_BITS <= MEM_BITS.
  // Parallel loads assume MEM_BITS is a multiple of the byte width.
  // The chain output sits high through reset and through own frames.
  // Readback output sits high whenever no frame is being sent.
  // Global tristate follows the request only while it serves that role.
  // Reconfiguration, through reset, clears the one-shot permission.

endmodule : cfgp_port
`default_nettype wire

// File: cfgp_pkg.sv
package cfgp_pkg;
  // Configuration source modes
  localparam logic [1:0] CFGP_MODE_SLAVE_SERIAL   = 2'h0;
  localparam logic [1:0] CFGP_MODE_SLAVE_PARALLEL = 2'h1;
  // Readback permission codes
  localparam logic [1:0] CFGP_RB_NONE      = 2'h0;
  localparam logic [1:0] CFGP_RB_ONCE      = 2'h1;
  localparam logic [1:0] CFGP_RB_UNLIMITED = 2'h2;
  // Capture modes for the logic-tile outputs
  localparam logic [1:0] CFGP_CAP_NONE   = 2'h0;
  localparam logic [1:0] CFGP_CAP_ENTRY  = 2'h1;
  localparam logic [1:0] CFGP_CAP_SIGNAL = 2'h2;
  localparam logic [1:0] CFGP_CAP_EITHER = 2'h3;
  // Field sizes and timing counts
  localparam int CFGP_BYTE_W      = 8;
  localparam int CFGP_PREAMBLE_W  = 8;
  localparam int CFGP_LENGTH_W    = 24;
  localparam int CFGP_HEADER_W    = 32;
  localparam logic [7:0] CFGP_PREAMBLE = 8'hF2;
  localparam int CFGP_RESTART_EDGES = 2;
  localparam int CFGP_RB_LATENCY    = 3;
  localparam int CFGP_TILE_OUTS     = 5;
  // Readback frame layout
  localparam int CFGP_FRAME_DATA_W  = 16;
  // Status carrier passed from link to system clock
  typedef struct packed {
    logic config_done;
    logic readback_busy;
    logic readback_spent;
  } cfgp_status_t;
  // Link state machine, one-hot
  typedef enum logic [3:0] {
    CFGP_ST_HEADER = 4'h1,
    CFGP_ST_LOAD   = 4'h2,
    CFGP_ST_PASS   = 4'h4,
    CFGP_ST_DONE   = 4'h8
  } cfgp_state_t;
  // Readback state machine, one-hot
  typedef enum logic [3:0] {
    CFGP_RB_IDLE  = 4'h1,
    CFGP_RB_WAIT  = 4'h2,
    CFGP_RB_SHIFT = 4'h4,
    CFGP_RB_HOLD  = 4'h8
  } cfgp_rb_state_t;
endpackage : cfgp_pkg

// File: cfgp_port_checker.sv
`timescale 1ns/100ps
`default_nettype none
// Link-side checks, all sampled on the rising config_clock
module cfgp_port_checker
  import cfgp_pkg::*;
#(
  parameter int MEM_BITS = 64            // Own memory size in bits
) (
  input wire logic       sys_rst,
  input wire logic       config_clock,
  input wire logic [1:0] mode_sel,
  input wire logic       din,
  input wire logic       readback_req_n,
  input wire logic [1:0] rb_permission,
  input wire logic       req_drives_readback,
  input wire logic       dout,
  input wire logic       readback_data,
  input wire logic       global_tristate,
  input wire logic       config_done
);
  localparam logic [15:0] OWN_END = 16'(32 + MEM_BITS); // Last own-bit echo slot
  logic [15:0] edge_cnt;                 // Link edges since reset, saturating
  logic        serial;                   // Serial chain mode selected
  assign serial = (mode_sel == CFGP_MODE_SLAVE_SERIAL);
  // Bit k of the stream shows on dout at count k
  always_ff @(posedge config_clock) begin
    if (sys_rst) begin
      edge_cnt <= 16'h0000;
    end else if (edge_cnt != 16'hFFFF) begin
      edge_cnt <= edge_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge config_clock);
  endclocking
  default disable iff (sys_rst);
  // Request held high, then taken low
  sequence s_req_fall;
    readback_req_n [*4] ##1 !readback_req_n;
  endsequence
  // Three idle slots, then the start bit
  sequence s_start_bit;
    readback_data [*3] ##1 !readback_data;
  endsequence
  property p_hdr_echo;
    serial && edge_cnt >= 16'h0001 && edge_cnt <= 16'h0020 |-> dout == $past(din);
  endproperty
  a_hdr_echo: assert property (p_hdr_echo) else $error("header bit not echoed");
  property p_own_high;
    serial && edge_cnt > 16'h0020 && edge_cnt <= OWN_END |-> dout;
  endproperty
  a_own_high: assert property (p_own_high) else $error("dout low on own frames");
  property p_pass_on;
    serial && edge_cnt > OWN_END |-> dout == $past(din);
  endproperty
  a_pass_on: assert property (p_pass_on) else $error("surplus bit not passed on");
  property p_par_quiet;
    mode_sel == CFGP_MODE_SLAVE_PARALLEL |-> dout;
  endproperty
  a_par_quiet: assert property (p_par_quiet) else $error("dout moved in parallel mode");
  property p_rb_start;
    s_req_fall ##0 (config_done && req_drives_readback && rb_permission == CFGP_RB_UNLIMITED)
      |-> ##1 s_start_bit;
  endproperty
  a_rb_start: assert property (p_rb_start) else $error("start bit latency wrong");
  property p_rb_gated;
    !readback_data |-> config_done && req_drives_readback;
  endproperty
  a_rb_gated: assert property (p_rb_gated) else $error("readback while not allowed");
  property p_rb_quiet;
    readback_req_n [*6] |-> readback_data;
  endproperty
  a_rb_quiet: assert property (p_rb_quiet) else $error("readback without request");
  property p_ts_before;
    (!config_done && !readback_req_n) [*2] |-> global_tristate;
  endproperty
  a_ts_before: assert property (p_ts_before) else $error("tristate not following pin");
endmodule : cfgp_port_checker
bind cfgp_port cfgp_port_checker #(.MEM_BITS(MEM_BITS)) cfgp_port_checker_i (
  .sys_rst, .config_clock, .mode_sel, .din, .readback_req_n, .rb_permission,
  .req_drives_readback, .dout, .readback_data, .global_tristate, .config_done
);
`default_nettype wire

// File: cfgp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host side; pins change just after a falling config_clock, except the first bit of each serial send
module cfgp_host_model (
  input  wire logic       config_clock,     // Link clock from the bench
  output var  logic       din,              // Serial bit
  output var  logic [7:0] data_bus,         // Parallel byte
  output var  logic       strobe_n,         // Strobe, active low
  output var  logic       chip_select_low,  // Select, active low
  output var  logic       chip_select_high, // Select, active high
  output var  logic       readback_req_n    // Request, active low
);
  // Idle: deselected, no request
  initial begin
    din = 1'b0;
    data_bus = 8'h00;
    strobe_n = 1'b1;
    chip_select_low = 1'b1;
    chip_select_high = 1'b0;
    readback_req_n = 1'b1;
  end
  // Stream MSB first, one bit per rising edge
  task automatic send_bits(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      din = v[i];
      @(posedge config_clock);
      @(negedge config_clock);
    end
    din = ~din; // Released line must not look like data
  endtask : send_bits
  // Select, then one byte per edge, kept selected to the end
  task automatic send_bytes(input logic [15:0] v, input int n);
    @(negedge config_clock);
    strobe_n = 1'b0;
    chip_select_low = 1'b0;
    chip_select_high = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge config_clock);
      data_bus = v[15 - 8*i -: 8];
    end
    @(negedge config_clock);
    strobe_n = 1'b1;
    chip_select_low = 1'b1;
    chip_select_high = 1'b0;
    data_bus = ~data_bus;
  endtask : send_bytes
  // Request level
  task automatic set_req(input logic v);
    @(negedge config_clock);
    readback_req_n = v;
  endtask : set_req
endmodule : cfgp_host_model
`default_nettype wire

// File: cfgp_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// Bench: host model on the link, plain ports elsewhere
module cfgp_port_tb_top;
  import cfgp_pkg::*;
  localparam logic [15:0] IMG = 16'hCA53; // Palindrome, so a bit-order fault would not show
  logic       clk, sys_rst, config_clock, din, strobe_n, chip_select_low, chip_select_high;
  logic       readback_req_n, req_drives_readback, capture_trig_n, dout, readback_data;
  logic       global_tristate, config_done, readback_busy, select_error;
  logic [1:0] mode_sel, rb_permission, capture_mode;
  logic [7:0] data_bus;
  logic [4:0] logic_tile, capture_mem;
  int         num_errors = 0;
  int         n_tests = 0;
  cfgp_port #(.MEM_BITS(16), .RB_BITS(16)) cfgp_port_i (
    .clk, .sys_rst, .config_clock, .mode_sel, .din, .data_bus, .strobe_n, .chip_select_low,
    .chip_select_high, .readback_req_n, .rb_permission, .req_drives_readback, .capture_mode,
    .capture_trig_n, .logic_tile, .dout, .readback_data, .global_tristate, .config_done,
    .readback_busy, .select_error, .capture_mem
  );
  cfgp_host_model cfgp_host_model_i (
    .config_clock, .din, .data_bus, .strobe_n, .chip_select_low, .chip_select_high,
    .readback_req_n
  );
  // Clocks, unrelated in phase
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    config_clock = 1'b0;
    #7;
    forever #80 config_clock = ~config_clock;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Long reset covers link edges; release just after a link edge
  task automatic setup(input logic [1:0] m, input logic [1:0] p, input logic drv,
                       input logic [1:0] cap, input logic [4:0] tile, input logic trig);
    @(posedge clk);
    sys_rst <= 1'b1;
    mode_sel <= m;
    rb_permission <= p;
    req_drives_readback <= drv;
    capture_mode <= cap;
    logic_tile <= tile;
    capture_trig_n <= trig;
    repeat (16) @(posedge clk);
    @(posedge config_clock);
    @(posedge clk);
    sys_rst <= 1'b0;
  endtask : setup
  task automatic load_serial;
    cfgp_host_model_i.send_bits(64'({CFGP_PREAMBLE, 24'h000038, IMG, 8'h6B}), 56);
  endtask : load_serial
  // Bounded wait for the loaded flag
  task automatic wait_done;
    for (int i = 0; i < 200 && config_done !== 1'b1; i++) @(posedge clk);
    chk(16'(config_done), 16'h0001);
  endtask : wait_done
  // Request, then judge nbits slots from the start bit; refused gives all ones
  task automatic rb_read(input logic ok, input int nbits);
    int f;
    cfgp_host_model_i.set_req(1'b0);
    repeat (3) @(negedge config_clock);
    for (int i = 0; i < nbits; i++) begin
      @(negedge config_clock);
      f = i % 18;
      chk(16'(!ok || f == 17 || (f != 0 && IMG[f-1])), 16'(readback_data));
    end
    cfgp_host_model_i.set_req(1'b1);
    repeat (4) @(posedge config_clock);
  endtask : rb_read
  task automatic t_serial;
    setup(CFGP_MODE_SLAVE_SERIAL, CFGP_RB_UNLIMITED, 1'b1, CFGP_CAP_ENTRY, 5'h15, 1'b1);
    load_serial;
    wait_done;
    rb_read(1'b1, 27);
    chk(16'(capture_mem), 16'h0015);
    rb_read(1'b1, 36);
    chk(16'(global_tristate), 16'h0000);
    $display("t_serial end");
  endtask : t_serial
  task automatic t_once;
    setup(CFGP_MODE_SLAVE_SERIAL, CFGP_RB_ONCE, 1'b1, CFGP_CAP_NONE, 5'h00, 1'b1);
    load_serial;
    wait_done;
    rb_read(1'b1, 18);
    rb_read(1'b0, 36);
    $display("t_once end");
  endtask : t_once
  task automatic t_none;
    setup(CFGP_MODE_SLAVE_SERIAL, CFGP_RB_NONE, 1'b1, CFGP_CAP_NONE, 5'h00, 1'b1);
    load_serial;
    wait_done;
    rb_read(1'b0, 36);
    @(posedge clk);
    req_drives_readback <= 1'b0;
    cfgp_host_model_i.set_req(1'b0);
    repeat (3) @(negedge config_clock);
    chk(16'(global_tristate), 16'h0001);
    cfgp_host_model_i.set_req(1'b1);
    $display("t_none end");
  endtask : t_none
  // Pin drives tristate before loading; continuous capture
  task automatic t_parallel;
    setup(CFGP_MODE_SLAVE_PARALLEL, CFGP_RB_UNLIMITED, 1'b1, CFGP_CAP_SIGNAL, 5'h0A, 1'b0);
    cfgp_host_model_i.set_req(1'b0);
    repeat (3) @(negedge config_clock);
    chk(16'(global_tristate), 16'h0001);
    cfgp_host_model_i.set_req(1'b1);
    cfgp_host_model_i.send_bytes(IMG, 2);
    wait_done;
    rb_read(1'b1, 18);
    chk(16'(capture_mem), 16'h000A);
    $display("t_parallel end");
  endtask : t_parallel
  // Deselect after one byte must be flagged
  task automatic t_deselect;
    setup(CFGP_MODE_SLAVE_PARALLEL, CFGP_RB_UNLIMITED, 1'b1, CFGP_CAP_NONE, 5'h00, 1'b1);
    cfgp_host_model_i.send_bytes(IMG, 1);
    repeat (12) @(posedge clk);
    chk(16'(select_error), 16'h0001);
    chk(16'(config_done), 16'h0000);
    $display("t_deselect end");
  endtask : t_deselect
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    mode_sel = CFGP_MODE_SLAVE_SERIAL;
    rb_permission = CFGP_RB_NONE;
    req_drives_readback = 1'b0;
    capture_mode = CFGP_CAP_NONE;
    capture_trig_n = 1'b1;
    logic_tile = 5'h00;
    repeat (4) @(posedge clk);
    t_serial;
    t_once;
    t_none;
    t_parallel;
    t_deselect;
    tally_and_finish;
  end
  // Watchdog, more than ten times the expected run
  initial begin
    #1000000;
    num_errors++;
    tally_and_finish;
  end
endmodule : cfgp_port_tb_top
`default_nettype wire
